// ### core/cmpc_pkg.sv
// package of the execution-context control block: register offsets, field positions,
// reset values, commands, priorities and the execution-mode type.
// assumes a 32-bit APB register port with byte addresses in the low 12 bits.
package cmpc_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [11:0] PSW_OFFSET = 12'h000;
  localparam logic [11:0] CMD_OFFSET = 12'h010;
  localparam logic [11:0] STAT_OFFSET = 12'h014;
  localparam logic [11:0] FAULT_OFFSET = 12'h018;

  // ==========================================================================
  // status word fields: lower half
  localparam int C_BIT = 0;
  localparam int Z_BIT = 1;
  localparam int N_BIT = 2;
  localparam int V_BIT = 3;
  localparam int Q_BIT = 4;
  localparam int L_BIT = 5;
  localparam int T_BIT = 14;
  localparam int R_BIT = 15;
  localparam int CC_W = 5;

  // status word fields: upper half
  localparam int GM_BIT = 16;
  localparam int I0M_BIT = 17;
  localparam int IRQ_LEVELS = 4;
  localparam int EM_BIT = 21;
  localparam int MODE_LSB = 22;
  localparam int MODE_W = 3;
  localparam int DBG_BIT = 26;
  localparam int SEC_BIT = 31;

  localparam logic [31:0] LOWER_WR_MASK = 32'h0000_C03F;
  localparam logic [31:0] UPPER_WR_MASK = 32'h01FF_0000;
  localparam logic [31:0] UPPER_HALF = 32'hFFFF_0000;
  localparam logic [31:0] IRQ_MASK_BITS = 32'h001E_0000;
  // supervisor mode with the global interrupt mask set
  localparam logic [31:0] PSW_RESET = 32'h0041_0000;

  // ==========================================================================
  // status and fault register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_PRIV_BIT = 4;
  localparam int STAT_DBG_BIT = 5;
  localparam int STAT_SEC_BIT = 6;
  localparam int STAT_EXC_PEND_BIT = 8;
  localparam int STAT_NMI_PEND_BIT = 9;
  localparam int FAULT_W = 4;
  localparam int FAULT_INSTR_BIT = 0;
  localparam int FAULT_SYSREG_BIT = 1;
  localparam int FAULT_MEM_BIT = 2;
  localparam int FAULT_SEC_BIT = 3;
  localparam logic [FAULT_W-1:0] FAULT_RESET = 4'h0;

  // ==========================================================================
  // software commands, written to the command register
  localparam logic [3:0] CMD_SCALL = 4'h1;
  localparam logic [3:0] CMD_RETE = 4'h2;
  localparam logic [3:0] CMD_RETD = 4'h3;
  localparam logic [3:0] CMD_SS_ENTER = 4'h4;
  localparam logic [3:0] CMD_SS_EXIT = 4'h5;

  // ==========================================================================
  // event priorities, 1 is highest, none for supervisor and application
  localparam logic [2:0] PRIO_NMI = 3'h1;
  localparam logic [2:0] PRIO_EXC = 3'h2;
  localparam logic [2:0] PRIO_INT0 = 3'h6;
  localparam logic [2:0] PRIO_NONE = 3'h7;

  typedef enum logic [MODE_W-1:0] {
    mode_app,
    mode_sup,
    mode_int0,
    mode_int1,
    mode_int2,
    mode_int3,
    mode_exc,
    mode_nmi
  } cmpc_mode_type;

endpackage

// ### core/cmpc_top.sv
// execution-context control: status word, mode priorities, privilege checks,
// debug state and secure state, with an APB slave for software access.
// assumes irq, nmi and debug request arrive from pins; core checks come on sys_clk.
//
// What this block does
// - status word is two 16-bit halves with distinct purposes.
// - lower half holds C Z N V Q flags plus R, T, L bits.
// - upper half holds mode, state and interrupt level masks.
// - event ranks fixed: NMI 1, exception 2, interrupts 3..0 at 3..6.
// - supervisor privileged, application unprivileged; neither has a rank.
// - only a higher-priority mode may preempt the running mode.
// - mode changes on software request, external interrupt or exception.
// - application mode refuses privileged instructions.
// - application mode blocks protected system registers and upper status half.
// - application mode denies protected memory accesses.
// - all other modes are privileged with full access.
// - reset leaves the core in supervisor mode.
// - debug state gives full register access including status word.
// - debug state allows privileged instructions.
// - entering debug sets every interrupt level mask.
// - in debug, clearing a level mask bit re-enables that level.
// - return-from-debug command leaves debug state.
// - secure state isolates secure resources from other code.
`timescale 1ns/1ps
`default_nettype none

module cmpc_top (
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event sources from pins
  input wire logic [cmpc_pkg::IRQ_LEVELS-1:0] irq_pin,
  input wire logic nmi_pin,
  input wire logic dbg_req_pin,
  // event and flag sources from the core
  input wire logic exc_req,
  input wire logic cc_we,
  input wire logic [cmpc_pkg::CC_W-1:0] cc_in,
  // access checks from the core
  input wire logic instr_valid,
  input wire logic instr_priv,
  input wire logic sysreg_valid,
  input wire logic sysreg_priv,
  input wire logic mem_valid,
  input wire logic mem_protected,
  input wire logic mem_secure,
  output logic instr_deny,
  output logic sysreg_deny,
  output logic mem_deny,
  // context state
  output logic [31:0] psw_out,
  output logic [cmpc_pkg::MODE_W-1:0] cur_mode,
  output logic privileged,
  output logic in_debug,
  output logic in_secure,
  output logic event_taken
);
  import cmpc_pkg::*;

  // ==========================================================================
  // state
  logic [31:0] psw;
  logic [31:0] saved_psw [0:7];
  logic [31:0] dbg_saved_psw;
  logic exc_pend;
  logic nmi_pend;
  logic [FAULT_W-1:0] faults;
  logic [IRQ_LEVELS-1:0] irq_meta, irq_sync;
  logic nmi_meta, nmi_sync, nmi_prev;
  logic dbg_meta, dbg_sync, dbg_prev;

  logic [31:0] next_psw;
  logic [31:0] next_saved_psw [0:7];
  logic [31:0] next_dbg_saved_psw;
  logic next_exc_pend;
  logic next_nmi_pend;
  logic [FAULT_W-1:0] next_faults;
  logic [IRQ_LEVELS-1:0] next_irq_meta, next_irq_sync;
  logic next_nmi_meta, next_nmi_sync, next_nmi_prev;
  logic next_dbg_meta, next_dbg_sync, next_dbg_prev;
  logic [31:0] next_prdata;
  logic next_instr_deny, next_sysreg_deny, next_mem_deny, next_event_taken;

  cmpc_mode_type mode;
  logic debug;
  logic secure;
  logic priv;
  logic [2:0] cur_prio;
  logic take_valid;
  cmpc_mode_type take_mode;
  logic dbg_take;
  logic nmi_rise;
  logic apb_wr;
  logic [3:0] cmd_code;
  logic psw_upper_ok;

  function automatic logic [2:0] cmpc_prio(input cmpc_mode_type m);
    logic [2:0] p;
    p = PRIO_NONE;
    case (m)
      mode_nmi: p = PRIO_NMI;
      mode_exc: p = PRIO_EXC;
      mode_int3: p = PRIO_INT0 - 3'h3;
      mode_int2: p = PRIO_INT0 - 3'h2;
      mode_int1: p = PRIO_INT0 - 3'h1;
      mode_int0: p = PRIO_INT0;
      default: p = PRIO_NONE;
    endcase
    return p;
  endfunction

  // ==========================================================================
  // decoded context
  assign mode = cmpc_mode_type'(psw[MODE_LSB +: MODE_W]);
  assign debug = psw[DBG_BIT];
  assign secure = psw[SEC_BIT];
  // debug state counts as privileged whatever the mode field says
  assign priv = (mode != mode_app) || debug;
  assign cur_prio = cmpc_prio(mode);
  assign nmi_rise = nmi_sync && !nmi_prev;
  assign dbg_take = dbg_sync && !dbg_prev && !debug;
  assign psw_upper_ok = priv;

  // ==========================================================================
  // event selection, highest priority first
  always_comb begin
    logic [2:0] lvl_prio;
    lvl_prio = PRIO_NONE;
    take_valid = 1'b0;
    take_mode = mode_app;
    if (nmi_pend && (PRIO_NMI < cur_prio)) begin
      take_valid = 1'b1;
      take_mode = mode_nmi;
    end else if (exc_pend && (PRIO_EXC < cur_prio)) begin
      take_valid = 1'b1;
      take_mode = mode_exc;
    end else begin
      for (int l = IRQ_LEVELS - 1; l >= 0; l--) begin
        lvl_prio = PRIO_INT0 - 3'(l);
        if (!take_valid && irq_sync[l] && !psw[GM_BIT] && !psw[I0M_BIT + l] && (lvl_prio < cur_prio)) begin
          take_valid = 1'b1;
          take_mode = cmpc_mode_type'(3'(mode_int0) + 3'(l));
        end
      end
    end
  end

  // ==========================================================================
  // apb handshake: an event entry stalls the access so no write is lost
  assign pready = !(take_valid || dbg_take);
  assign apb_wr = psel && penable && pwrite && pready;
  assign cmd_code = pwdata[3:0];

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        PSW_OFFSET: pslverr = pwrite && !psw_upper_ok && (pstrb[3:2] != 2'b00);
        CMD_OFFSET: begin
          if (pwrite) begin
            case (cmd_code)
              CMD_SCALL: pslverr = 1'b0;
              CMD_RETE: pslverr = !priv || (mode == mode_app);
              CMD_RETD: pslverr = !debug;
              CMD_SS_ENTER: pslverr = !priv;
              CMD_SS_EXIT: pslverr = !secure;
              default: pslverr = 1'b1;
            endcase
          end
        end
        STAT_OFFSET: pslverr = pwrite;
        FAULT_OFFSET: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

  // ==========================================================================
  // read data, sampled every cycle of a read so it is stable in the access phase
  always_comb begin
    next_prdata = prdata;
    if (psel && !pwrite) begin
      case (paddr)
        PSW_OFFSET: next_prdata = psw_upper_ok ? psw : (psw & ~UPPER_HALF);
        STAT_OFFSET: begin
          next_prdata = 32'h0000_0000;
          next_prdata[STAT_MODE_LSB +: MODE_W] = psw[MODE_LSB +: MODE_W];
          next_prdata[STAT_PRIV_BIT] = priv;
          next_prdata[STAT_DBG_BIT] = debug;
          next_prdata[STAT_SEC_BIT] = secure;
          next_prdata[STAT_EXC_PEND_BIT] = exc_pend;
          next_prdata[STAT_NMI_PEND_BIT] = nmi_pend;
        end
        FAULT_OFFSET: next_prdata = {28'h000_0000, faults};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // status word, saved contexts, pending events and faults
  always_comb begin
    logic [31:0] wmask;
    wmask = 32'h0000_0000;
    next_psw = psw;
    next_saved_psw = saved_psw;
    next_dbg_saved_psw = dbg_saved_psw;
    next_event_taken = 1'b0;
    if (cc_we) begin
      next_psw[CC_W-1:0] = cc_in;
    end
    if (dbg_take) begin
      next_dbg_saved_psw = psw;
      // built on next_psw so a flag update in the same cycle survives the entry
      next_psw = next_psw | IRQ_MASK_BITS;
      next_psw[DBG_BIT] = 1'b1;
    end else if (take_valid) begin
      next_saved_psw[take_mode] = psw;
      next_psw[MODE_LSB +: MODE_W] = 3'(take_mode);
      next_event_taken = 1'b1;
    end else if (apb_wr && !pslverr) begin
      case (paddr)
        PSW_OFFSET: begin
          wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
          wmask = wmask & (LOWER_WR_MASK | (psw_upper_ok ? UPPER_WR_MASK : 32'h0000_0000));
          // clearing a level mask here is how the monitor re-opens a level
          next_psw = (next_psw & ~wmask) | (pwdata & wmask);
        end
        CMD_OFFSET: begin
          case (cmd_code)
            CMD_SCALL: begin
              next_saved_psw[mode_sup] = psw;
              next_psw[MODE_LSB +: MODE_W] = 3'(mode_sup);
            end
            CMD_RETE: next_psw = saved_psw[mode];
            CMD_RETD: next_psw = dbg_saved_psw;
            CMD_SS_ENTER: next_psw[SEC_BIT] = 1'b1;
            CMD_SS_EXIT: next_psw[SEC_BIT] = 1'b0;
            default: next_psw = psw;
          endcase
        end
        default: next_psw = psw;
      endcase
    end
  end

  always_comb begin
    // a new request in the cycle it is taken stays pending
    next_exc_pend = (exc_pend && !(take_valid && (take_mode == mode_exc))) || exc_req;
    next_nmi_pend = (nmi_pend && !(take_valid && (take_mode == mode_nmi))) || nmi_rise;
    next_faults = faults;
    if (apb_wr && (paddr == FAULT_OFFSET)) begin
      next_faults = faults & ~pwdata[FAULT_W-1:0];
    end
    if (instr_valid && instr_priv && !priv) begin
      next_faults[FAULT_INSTR_BIT] = 1'b1;
    end
    if (sysreg_valid && sysreg_priv && !priv) begin
      next_faults[FAULT_SYSREG_BIT] = 1'b1;
    end
    if (mem_valid && mem_protected && !priv) begin
      next_faults[FAULT_MEM_BIT] = 1'b1;
    end
    if (mem_valid && mem_secure && !secure) begin
      next_faults[FAULT_SEC_BIT] = 1'b1;
    end
    if (psel && penable && pready && pwrite && (paddr == CMD_OFFSET) && pslverr && !priv) begin
      next_faults[FAULT_INSTR_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      psw <= PSW_RESET;
      for (int i = 0; i < 8; i++) begin
        saved_psw[i] <= PSW_RESET;
      end
      dbg_saved_psw <= PSW_RESET;
      exc_pend <= 1'b0;
      nmi_pend <= 1'b0;
      faults <= FAULT_RESET;
      event_taken <= 1'b0;
    end else begin
      psw <= next_psw;
      saved_psw <= next_saved_psw;
      dbg_saved_psw <= next_dbg_saved_psw;
      exc_pend <= next_exc_pend;
      nmi_pend <= next_nmi_pend;
      faults <= next_faults;
      event_taken <= next_event_taken;
    end
  end

  // ==========================================================================
  // pin synchronisers; only the second stage and the nmi and debug edge-detect stages are looked at
  always_comb begin
    next_irq_meta = irq_pin;
    next_irq_sync = irq_meta;
    next_nmi_meta = nmi_pin;
    next_nmi_sync = nmi_meta;
    next_nmi_prev = nmi_sync;
    next_dbg_meta = dbg_req_pin;
    next_dbg_sync = dbg_meta;
    next_dbg_prev = dbg_sync;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_meta <= '0;
      irq_sync <= '0;
      nmi_meta <= 1'b0;
      nmi_sync <= 1'b0;
      nmi_prev <= 1'b0;
      dbg_meta <= 1'b0;
      dbg_sync <= 1'b0;
      dbg_prev <= 1'b0;
    end else begin
      irq_meta <= next_irq_meta;
      irq_sync <= next_irq_sync;
      nmi_meta <= next_nmi_meta;
      nmi_sync <= next_nmi_sync;
      nmi_prev <= next_nmi_prev;
      dbg_meta <= next_dbg_meta;
      dbg_sync <= next_dbg_sync;
      dbg_prev <= next_dbg_prev;
    end
  end

  // ==========================================================================
  // access checks, answered one cycle after the request
  always_comb begin
    next_instr_deny = instr_valid && instr_priv && !priv;
    next_sysreg_deny = sysreg_valid && sysreg_priv && !priv;
    // secure resources stay closed even to debug and system modes
    next_mem_deny = mem_valid && ((mem_protected && !priv) || (mem_secure && !secure));
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      instr_deny <= 1'b0;
      sysreg_deny <= 1'b0;
      mem_deny <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      instr_deny <= next_instr_deny;
      sysreg_deny <= next_sysreg_deny;
      mem_deny <= next_mem_deny;
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // context outputs
  assign psw_out = psw;
  assign cur_mode = psw[MODE_LSB +: MODE_W];
  assign privileged = priv;
  assign in_debug = debug;
  assign in_secure = secure;

endmodule

`default_nettype wire

// ### core/cmpc_unused_placeholder_none.sv
// intentionally empty: no further design files
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### sim/cmpc_top_checker.sv
// checker of the execution-context block: port relations of the top module.
// assumes the single sys_clk domain and the asynchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none

module cmpc_top_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire logic cc_we,
  input wire logic [cmpc_pkg::CC_W-1:0] cc_in,
  input wire logic instr_valid,
  input wire logic instr_priv,
  input wire logic sysreg_valid,
  input wire logic sysreg_priv,
  input wire logic mem_valid,
  input wire logic mem_protected,
  input wire logic mem_secure,
  input wire logic instr_deny,
  input wire logic sysreg_deny,
  input wire logic mem_deny,
  input wire logic [31:0] psw_out,
  input wire logic [cmpc_pkg::MODE_W-1:0] cur_mode,
  input wire logic privileged,
  input wire logic in_debug,
  input wire logic in_secure,
  input wire logic event_taken
);
  import cmpc_pkg::*;
  // ==========================================================================
  // helpers and sequences
  wire logic apb_wr = psel && penable && pwrite;
  wire logic user = !privileged && !in_debug;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // a rise into an event mode that no software write explains
  sequence s_mode_up;
    cur_mode > $past(cur_mode) && cur_mode >= 3'h2 && !$past(apb_wr);
  endsequence

  // ==========================================================================
  // assertions
  chk_reset_sup: assert property ($fell(rst) |-> cur_mode == mode_sup && privileged)
    else $error("mode after reset is not supervisor");
  chk_mode_slice: assert property (cur_mode == psw_out[24:22])
    else $error("mode output differs from the status word");
  chk_priv_decode: assert property (!in_debug |-> privileged == (cur_mode != 3'h0))
    else $error("privilege does not follow the mode");
  chk_instr_deny: assert property (1 |=> instr_deny == $past(instr_valid && instr_priv && user))
    else $error("privileged instruction check wrong");
  chk_sysreg_deny: assert property (1 |=> sysreg_deny == $past(sysreg_valid && sysreg_priv && user))
    else $error("system register check wrong");
  chk_mem_deny: assert property (1 |=> mem_deny ==
    $past(mem_valid && ((mem_protected && user) || (mem_secure && !in_secure))))
    else $error("memory check wrong");
  chk_debug_masks: assert property ($rose(in_debug) |-> psw_out[20:17] == 4'hF)
    else $error("interrupt masks not set on debug entry");
  chk_cc_update: assert property (cc_we && !apb_wr |=> psw_out[4:0] == $past(cc_in))
    else $error("condition flags not written");
  chk_upper_refuse: assert property (apb_wr && paddr == PSW_OFFSET && pstrb[3:2] != 2'h0 && user |-> pslverr)
    else $error("upper status write accepted in application mode");
  chk_event_pulse: assert property (s_mode_up |-> ##[0:1] event_taken)
    else $error("event entry without event pulse");
  chk_mode_drop: assert property (cur_mode < $past(cur_mode) |-> $past(apb_wr))
    else $error("mode fell without a software request");
endmodule

bind cmpc_top cmpc_top_checker u_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pstrb, .pslverr,
  .cc_we, .cc_in, .instr_valid, .instr_priv, .sysreg_valid, .sysreg_priv, .mem_valid, .mem_protected,
  .mem_secure, .instr_deny, .sysreg_deny, .mem_deny, .psw_out, .cur_mode, .privileged, .in_debug,
  .in_secure, .event_taken);
`default_nettype wire

// ### sim/tb_cmpc_top.sv
// self-checking bench of the execution-context block, random lower-half traffic.
// assumes the checker binds itself and the clock runs at 40 MHz.
`timescale 1ns/1ps
`default_nettype none

module tb_cmpc_top;
  import cmpc_pkg::*;
  logic sys_clk;
  logic rst;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, psw_out;
  logic [3:0] pstrb, irq_pin;
  logic nmi_pin, dbg_req_pin, exc_req, cc_we;
  logic [CC_W-1:0] cc_in;
  logic instr_valid, instr_priv, sysreg_valid, sysreg_priv, mem_valid, mem_protected, mem_secure;
  logic instr_deny, sysreg_deny, mem_deny, privileged, in_debug, in_secure, event_taken;
  logic [MODE_W-1:0] cur_mode;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int waits = 0;
  int seed = 59308;

  cmpc_top dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .irq_pin, .nmi_pin, .dbg_req_pin, .exc_req, .cc_we, .cc_in, .instr_valid, .instr_priv, .sysreg_valid,
    .sysreg_priv, .mem_valid, .mem_protected, .mem_secure, .instr_deny, .sysreg_deny, .mem_deny, .psw_out,
    .cur_mode, .privileged, .in_debug, .in_secure, .event_taken);

  // ==========================================================================
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ==========================================================================
  // tasks, each entered just after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // lower half after a software write: only the writable flag and control bits change
  function automatic logic [15:0] exp_lower(input logic [31:0] w);
    return w[15:0] & LOWER_WR_MASK[15:0];
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; the trailing idle edge keeps psel from being set twice in one step
  // waits counts the stalled access edges; a wait ends when pready rises, or at the hang guard if it never does
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    pstrb <= s;
    step(1);
    penable <= 1'b1;
    step(1);
    waits = 0;
    while (pready !== 1'b1) begin
      waits++;
      step(1);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    step(1);
  endtask

  task automatic cmd(input logic [3:0] c);
    apb(1'b1, CMD_OFFSET, {28'h0, c}, 4'hF);
  endtask

  // one access check; the deny flags answer one edge later
  task automatic acc(input logic [6:0] v, input logic [2:0] exp);
    {instr_valid, instr_priv, sysreg_valid, sysreg_priv, mem_valid, mem_protected, mem_secure} <= v;
    step(1);
    {instr_valid, instr_priv, sysreg_valid, sysreg_priv, mem_valid, mem_protected, mem_secure} <= 7'h0;
    step(1);
    check("deny", exp, {instr_deny, sysreg_deny, mem_deny});
  endtask

  // pin levels allow two sync edges plus the entry edge before the mode is read
  task automatic raise(input logic [3:0] i, input logic e, input logic n, input logic [2:0] m);
    irq_pin <= i;
    exc_req <= e;
    nmi_pin <= n;
    step(1);
    exc_req <= 1'b0;
    step(5);
    check("mode", m, cur_mode);
  endtask

  task automatic do_reset();
    step(1);
    rst <= 1'b1;
    step(2);
    rst <= 1'b0;
    step(1);
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, nmi_pin, dbg_req_pin, exc_req, cc_we} = '0;
    {instr_valid, instr_priv, sysreg_valid, sysreg_priv, mem_valid, mem_protected, mem_secure} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    irq_pin = '0;
    cc_in = '0;
    do_reset();
    check("psw", PSW_RESET, psw_out);
    apb(1'b0, STAT_OFFSET, 32'h0, 4'h0);
    check("stat", 32'h11, rd);
    apb(1'b1, STAT_OFFSET, 32'h0, 4'hF);
    check("stat write", 32'h1, er);
    apb(1'b0, 12'hFFC, 32'h0, 4'h0);
    check("unmapped", 32'h1, er);
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      apb(1'b1, PSW_OFFSET, d, 4'h3);
      check("psw lower", exp_lower(d), psw_out[15:0]);
      check("psw upper", PSW_RESET, psw_out & UPPER_HALF);
      cc_we <= 1'b1;
      cc_in <= d[20:16];
      step(1);
      cc_we <= 1'b0;
      step(1);
      check("flags", d[20:16], psw_out[4:0]);
    end
    // application mode with level 0 masked
    apb(1'b1, PSW_OFFSET, 32'h0002_0000, 4'hC);
    check("privileged", 32'h0, privileged);
    acc(7'b1100000, 3'b100);
    acc(7'b0011000, 3'b010);
    acc(7'b0000110, 3'b001);
    acc(7'b1010100, 3'b000);
    apb(1'b1, PSW_OFFSET, 32'h0040_0000, 4'hC);
    check("upper refused", 32'h1, er);
    apb(1'b0, PSW_OFFSET, 32'h0, 4'h0);
    check("app read", 32'h0, rd & UPPER_HALF);
    check("psw kept", 32'h0002_0000, psw_out & UPPER_HALF);
    apb(1'b0, FAULT_OFFSET, 32'h0, 4'h0);
    check("faults", 32'h7, rd);
    cmd(CMD_SCALL);
    check("mode", mode_sup, cur_mode);
    acc(7'b1111110, 3'b000);
    apb(1'b1, FAULT_OFFSET, 32'h7, 4'hF);
    apb(1'b0, FAULT_OFFSET, 32'h0, 4'h0);
    check("faults cleared", 32'h0, rd);
    // nested events, all levels open
    apb(1'b1, PSW_OFFSET, 32'h0040_0000, 4'hC);
    // the level 0 entry lands on the access edge of this read and stalls it once
    irq_pin <= 4'h1;
    step(1);
    apb(1'b0, STAT_OFFSET, 32'h0, 4'h0);
    check("entry stall", 32'h1, waits);
    check("mode", mode_int0, cur_mode);
    raise(4'h1, 1'b0, 1'b0, mode_int0);
    raise(4'h5, 1'b0, 1'b0, mode_int2);
    raise(4'h7, 1'b0, 1'b0, mode_int2);
    raise(4'h7, 1'b1, 1'b0, mode_exc);
    raise(4'h7, 1'b0, 1'b1, mode_nmi);
    cmd(CMD_RETE);
    check("mode", mode_exc, cur_mode);
    irq_pin <= 4'h0;
    nmi_pin <= 1'b0;
    // debug from application mode, after a second reset
    do_reset();
    apb(1'b1, PSW_OFFSET, 32'h0, 4'hC);
    dbg_req_pin <= 1'b1;
    step(6);
    check("debug", 32'h1, in_debug);
    check("debug psw", 32'h041E_0000, psw_out & UPPER_HALF);
    acc(7'b1100000, 3'b000);
    apb(1'b1, PSW_OFFSET, 32'h0016_0000, 4'hC);
    check("debug write", 32'h0, er);
    check("level 2 open", 32'h0416_0000, psw_out & UPPER_HALF);
    cmd(CMD_RETD);
    check("debug left", 32'h0, in_debug);
    check("psw restored", 32'h0, psw_out & UPPER_HALF);
    acc(7'b1100000, 3'b100);
    cmd(CMD_RETD);
    check("retd refused", 32'h1, er);
    cmd(CMD_RETE);
    check("rete refused", 32'h1, er);
    cmd(CMD_SS_ENTER);
    check("enter refused", 32'h1, er);
    cmd(4'hF);
    check("bad command", 32'h1, er);
    dbg_req_pin <= 1'b0;
    // secure state
    cmd(CMD_SCALL);
    cmd(CMD_SS_ENTER);
    check("secure", 32'h1, in_secure);
    acc(7'b0000111, 3'b000);
    cmd(CMD_SS_EXIT);
    acc(7'b0000111, 3'b001);
    cmd(CMD_SS_EXIT);
    check("exit refused", 32'h1, er);
    print_verdict();
  end
endmodule
`default_nettype wire
